// >>> rtl/fcp_port_ctrl.sv
// Feature connector port control: pin direction, routing and pixel capture.
// Assumes pins are resolved outside from _o/_oe; pixel_input_clock is free.
// Functional notes
// RULE1 - Enable pin low when enabled and field 00
// RULE2 - Enable bit gates every connector function
// RULE3 - Sync select low makes syncs, blank inputs
// RULE4 - Blank input low turns video off
// RULE5 - Pixel select low: bus input, clocked in
// RULE6 - Pixclk select low: pin feeds palette DAC
// RULE7 - Pixclk pin as input is test only
// RULE8 - Pixclk function only while port enabled
// RULE9 - Clock select bit enables input capture
// RULE10 - Input clock only in native 16-bit mode
// RULE11 - Native and compat modes use different pins
// RULE12 - Input groups release their output drivers
`timescale 1ns/100ps
module fcp_port_ctrl
  import fcp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_sync_select,
  input wire logic compat_external_sync_select,
  input wire logic external_pixel_select,
  input wire logic compat_external_pixel_select,
  input wire logic external_pixclk_select,
  input wire logic compat_external_pixclk_select,
  input wire logic hsync_i,
  output logic hsync_o,
  output logic hsync_oe,
  input wire logic vsync_i,
  output logic vsync_o,
  output logic vsync_oe,
  input wire logic blank_n_i,
  output logic blank_n_o,
  output logic blank_n_oe,
  input wire logic compat_blank_n_i,
  output logic compat_blank_n_o,
  output logic compat_blank_n_oe,
  input wire logic [PIX_W-1:0] pixel_bus_i,
  output logic [PIX_W-1:0] pixel_bus_o,
  output logic [PIX_W-1:0] pixel_bus_oe,
  output logic [PIX_W-1:0] compat_pixel_bus_o,
  output logic [PIX_W-1:0] compat_pixel_bus_oe,
  input wire logic pixel_clock_pin_i,
  output logic pixel_clock_pin_o,
  output logic pixel_clock_pin_oe,
  output logic feature_port_enable_n,
  input wire logic pixel_input_clock,
  input wire fcp_video_t vid_in,
  input wire logic [PIX_W-1:0] vid_pixel,
  input wire logic vid_pixclk,
  output logic video_off,
  output fcp_video_t ext_video,
  output logic dac_ext_clk_sel,
  output logic [PIX_W-1:0] dac_pixel,
  output logic dac_pixel_valid
);
  // ---------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------
  fcp_ctrl_t ctrl_r;
  logic [1:0] pinfn_r;
  logic clksel_r;
  logic [PIX_W-1:0] pixdata_r;
  // ---------------------------------------------------------------------
  // Pin input synchronisers
  // ---------------------------------------------------------------------
  logic [N_SYNC-1:0] raw;
  logic [N_SYNC-1:0] s1_r;
  logic [N_SYNC-1:0] s2_r;
  assign raw = {pixel_clock_pin_i, vsync_i, hsync_i, compat_blank_n_i,
    blank_n_i, compat_external_pixclk_select, external_pixclk_select,
    compat_external_pixel_select, external_pixel_select,
    compat_external_sync_select, external_sync_select};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= '0;
      s2_r <= '0;
    end else if (ce) begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end
  // ---------------------------------------------------------------------
  // Mode and direction decode
  // ---------------------------------------------------------------------
  logic act_nat;
  logic act_cmp;
  fcp_sel_t sel;
  logic blank_in;
  logic sync_in;
  logic pix_in;
  logic cap_en;
  assign act_nat = ctrl_r.en & ctrl_r.native; // RULE2
  assign act_cmp = ctrl_r.en & ~ctrl_r.native; // RULE2
  // Each mode reads its selects from its own pin positions
  assign sel.sync = ctrl_r.native ? s2_r[0] : s2_r[1]; // RULE11
  assign sel.pix = ctrl_r.native ? s2_r[2] : s2_r[3]; // RULE11
  assign sel.pixclk = ctrl_r.native ? s2_r[4] : s2_r[5]; // RULE11
  assign blank_in = ctrl_r.native ? s2_r[6] : s2_r[7]; // RULE11
  assign sync_in = ctrl_r.en & ~sel.sync; // RULE3
  assign pix_in = ctrl_r.en & ~sel.pix; // RULE5
  assign cap_en = act_nat & ctrl_r.wide16 & clksel_r & ~sel.pix; // RULE10
  // ---------------------------------------------------------------------
  // Pin drivers, all registered
  // ---------------------------------------------------------------------
  logic [PIX_W-1:0] width_mask;
  assign width_mask = ctrl_r.wide16 ? {PIX_W{1'b1}}
    : {{(PIX_W-NARROW_W){1'b0}}, {NARROW_W{1'b1}}};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      feature_port_enable_n <= 1'b1;
      hsync_oe <= 1'b0;
      vsync_oe <= 1'b0;
      blank_n_oe <= 1'b0;
      compat_blank_n_oe <= 1'b0;
      pixel_bus_oe <= '0;
      compat_pixel_bus_oe <= '0;
      pixel_clock_pin_oe <= 1'b0;
    end else if (ce) begin
      feature_port_enable_n <=
        ~(ctrl_r.en & (pinfn_r == PINFN_FEATURE)); // RULE1
      hsync_oe <= ctrl_r.en & sel.sync; // RULE3 RULE12
      vsync_oe <= ctrl_r.en & sel.sync; // RULE3 RULE12
      blank_n_oe <= act_nat & sel.sync; // RULE11 RULE12
      compat_blank_n_oe <= act_cmp & sel.sync; // RULE11 RULE12
      pixel_bus_oe <= {PIX_W{act_nat & sel.pix}} & width_mask; // RULE5
      compat_pixel_bus_oe <= {PIX_W{act_cmp & sel.pix}}; // RULE11
      pixel_clock_pin_oe <= ctrl_r.en & sel.pixclk; // RULE6 RULE8
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hsync_o <= 1'b0;
      vsync_o <= 1'b0;
      blank_n_o <= 1'b0;
      compat_blank_n_o <= 1'b0;
      pixel_bus_o <= '0;
      compat_pixel_bus_o <= '0;
      pixel_clock_pin_o <= 1'b0;
    end else if (ce) begin
      hsync_o <= vid_in.hs;
      vsync_o <= vid_in.vs;
      blank_n_o <= vid_in.blank;
      compat_blank_n_o <= vid_in.blank;
      pixel_bus_o <= vid_pixel;
      compat_pixel_bus_o <= vid_pixel;
      pixel_clock_pin_o <= vid_pixclk;
    end
  end
  // ---------------------------------------------------------------------
  // Inward video status
  // ---------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      video_off <= 1'b0;
      ext_video <= '0;
      dac_ext_clk_sel <= 1'b0;
    end else if (ce) begin
      video_off <= sync_in & ~blank_in; // RULE4
      ext_video.hs <= sync_in & s2_r[8]; // RULE3
      ext_video.vs <= sync_in & s2_r[9]; // RULE3
      ext_video.blank <= sync_in & blank_in; // RULE3
      // Pin clock only steers the DAC source; its level is test status
      dac_ext_clk_sel <= ctrl_r.en & ~sel.pixclk; // RULE6 RULE7 RULE8
    end
  end
  // ---------------------------------------------------------------------
  // Pixel capture on the input clock
  // ---------------------------------------------------------------------
  logic lrst1_r;
  logic lrst2_r;
  logic cen1_r;
  logic cen2_r;
  logic ack1_r;
  logic ack2_r;
  logic req_r;
  logic [PIX_W-1:0] word_r;
  logic rq1_r;
  logic rq2_r;
  logic ack_r;
  always_ff @(posedge pixel_input_clock) begin
    lrst1_r <= aresetn;
    lrst2_r <= lrst1_r;
  end
  always_ff @(posedge pixel_input_clock) begin
    if (!lrst2_r) begin
      cen1_r <= 1'b0;
      cen2_r <= 1'b0;
      ack1_r <= 1'b0;
      ack2_r <= 1'b0;
    end else begin
      cen1_r <= cap_en;
      cen2_r <= cen1_r;
      ack1_r <= ack_r;
      ack2_r <= ack1_r;
    end
  end
  // Words arriving while a handshake is open are dropped, not queued
  always_ff @(posedge pixel_input_clock) begin
    if (!lrst2_r) begin
      req_r <= 1'b0;
      word_r <= '0;
    end else if (cen2_r && (req_r == ack2_r)) begin // RULE9 RULE10
      word_r <= pixel_bus_i; // RULE5
      req_r <= ~req_r;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rq1_r <= 1'b0;
      rq2_r <= 1'b0;
    end else if (ce) begin
      rq1_r <= req_r;
      rq2_r <= rq1_r;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_r <= 1'b0;
      dac_pixel <= '0;
      dac_pixel_valid <= 1'b0;
      pixdata_r <= '0;
    end else if (ce) begin
      dac_pixel_valid <= 1'b0;
      if (rq2_r != ack_r) begin
        ack_r <= rq2_r;
        dac_pixel <= word_r; // RULE9
        pixdata_r <= word_r;
        dac_pixel_valid <= 1'b1;
      end
    end
  end
  // ---------------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------------
  logic aw_got_r;
  logic w_got_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [7:0] wbyte_r;
  logic wbe_r;
  logic wr_go;
  assign wr_go = aw_got_r & w_got_r & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      waddr_r <= '0;
      wbyte_r <= '0;
      wbe_r <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= ~aw_got_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_got_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        waddr_r <= s_axi_awaddr[ADDR_W-1:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wbyte_r <= s_axi_wdata[7:0];
        wbe_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (waddr_r > OFS_PIXDATA || waddr_r[1:0] != 2'h0)
          ? RESP_DECERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      pinfn_r <= PINFN_RST;
      clksel_r <= PIXCFG_RST;
    end else if (ce && wr_go && wbe_r) begin
      unique case (waddr_r)
        OFS_CTRL: ctrl_r <= wbyte_r[CTRL_WIDE_BIT:CTRL_EN_BIT]; // RULE2
        OFS_PINFN: pinfn_r <= wbyte_r[1:0]; // RULE1
        OFS_PIXCFG: clksel_r <= wbyte_r[PIXCFG_CLKSEL_BIT]; // RULE9
        default: ;
      endcase
    end
  end
  // ---------------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------------
  logic [31:0] rd_nxt;
  logic [1:0] rresp_nxt;
  logic [ADDR_W-1:0] raddr;
  assign raddr = s_axi_araddr[ADDR_W-1:0];
  always_comb begin
    rd_nxt = 32'h0000_0000;
    rresp_nxt = RESP_OKAY;
    unique case (raddr)
      OFS_CTRL: rd_nxt[2:0] = ctrl_r;
      OFS_PINFN: rd_nxt[1:0] = pinfn_r;
      OFS_PIXCFG: rd_nxt[PIXCFG_CLKSEL_BIT] = clksel_r;
      // Pin clock level is sampled only for test visibility
      OFS_STATUS: rd_nxt[8:0] = {cap_en, video_off, s2_r[10],
        s2_r[9], s2_r[8], blank_in, sel}; // RULE7
      OFS_PIXDATA: rd_nxt[PIX_W-1:0] = pixdata_r;
      default: rresp_nxt = RESP_DECERR;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_nxt;
        s_axi_rresp <= rresp_nxt;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// >>> rtl/fcp_pkg.sv
// Package: constants and carrier types for the feature port control block.
// Assumes a 32-bit AXI4-Lite master and registers at word offsets.
package fcp_pkg;
  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_PINFN = 5'h04;
  localparam logic [4:0] OFS_PIXCFG = 5'h08;
  localparam logic [4:0] OFS_STATUS = 5'h0C;
  localparam logic [4:0] OFS_PIXDATA = 5'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_NATIVE_BIT = 1;
  localparam int CTRL_WIDE_BIT = 2;
  localparam int PIXCFG_CLKSEL_BIT = 1;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [1:0] PINFN_RST = 2'h0;
  localparam logic [1:0] PINFN_FEATURE = 2'h0;
  localparam logic PIXCFG_RST = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ---------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------
  localparam int PIX_W = 16;
  localparam int NARROW_W = 8;
  localparam int N_SYNC = 11;
  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic wide16;
    logic native;
    logic en;
  } fcp_ctrl_t;
  typedef struct packed {
    logic pixclk;
    logic pix;
    logic sync;
  } fcp_sel_t;
  typedef struct packed {
    logic hs;
    logic vs;
    logic blank;
  } fcp_video_t;
endpackage

// >>> tb/fcp_checker.sv
// Checker: pin direction and capture relations at the port control pins.
// Assumes aclk domain only; bound to every fcp_port_ctrl instance.
`timescale 1ns/100ps
module fcp_checker
  import fcp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hsync_oe,
  input wire logic vsync_oe,
  input wire logic blank_n_oe,
  input wire logic compat_blank_n_oe,
  input wire logic [PIX_W-1:0] pixel_bus_oe,
  input wire logic [PIX_W-1:0] compat_pixel_bus_oe,
  input wire logic video_off,
  input wire logic pixel_clock_pin_oe,
  input wire logic dac_ext_clk_sel,
  input wire logic dac_pixel_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_SYNC_PAIR: assert property (hsync_oe == vsync_oe)
    else $error("sync pins differ in direction");
  AST_BLANK_POS: assert property (!(blank_n_oe && compat_blank_n_oe))
    else $error("blank driven at both positions");
  AST_PIX_POS: assert property (!(|pixel_bus_oe && |compat_pixel_bus_oe))
    else $error("pixel bus driven at both positions");
  AST_PIX_LOW: assert property (|pixel_bus_oe |-> &pixel_bus_oe[7:0])
    else $error("pixel bus low byte partly driven");
  // Settle margin, select path and blank path differ in latency
  AST_VOFF: assert property (video_off[*6] |-> !hsync_oe && !blank_n_oe)
    else $error("video off while syncs driven");
  AST_CLK_DIR: assert property (pixel_clock_pin_oe[*6] |-> !dac_ext_clk_sel)
    else $error("dac on pin clock while pin driven");
  AST_VALID_PULSE: assert property (dac_pixel_valid |=> !dac_pixel_valid)
    else $error("capture strobe longer than a cycle");
  AST_CAP_IN: assert property (dac_pixel_valid |-> pixel_bus_oe == '0)
    else $error("capture while pixel bus driven");
  cover property (dac_pixel_valid);
  cover property (video_off);
  cover property (pixel_clock_pin_oe ##1 !pixel_clock_pin_oe);
endmodule

bind fcp_port_ctrl fcp_checker chk (.aclk, .aresetn, .hsync_oe,
  .vsync_oe, .blank_n_oe, .compat_blank_n_oe, .pixel_bus_oe,
  .compat_pixel_bus_oe, .video_off, .pixel_clock_pin_oe,
  .dac_ext_clk_sel, .dac_pixel_valid);

// >>> tb/fcp_ext_dev.sv
// Partner: video device on the far side of the feature connector.
// Assumes the bench picks its selects, frame window and next word.
`timescale 1ns/100ps
module fcp_ext_dev
  import fcp_pkg::*;
(
  input wire fcp_sel_t sel,
  input wire logic cmp,
  input wire logic frame,
  input wire logic [PIX_W-1:0] next_word,
  output logic external_sync_select,
  output logic compat_external_sync_select,
  output logic external_pixel_select,
  output logic compat_external_pixel_select,
  output logic external_pixclk_select,
  output logic compat_external_pixclk_select,
  output logic pixel_input_clock,
  output logic [PIX_W-1:0] word
);
  // Unused position shows the opposite level, so misrouting shows
  assign external_sync_select = sel.sync ^ cmp;
  assign compat_external_sync_select = sel.sync ^ !cmp;
  assign external_pixel_select = sel.pix ^ cmp;
  assign compat_external_pixel_select = sel.pix ^ !cmp;
  assign external_pixclk_select = sel.pixclk ^ cmp;
  assign compat_external_pixclk_select = sel.pixclk ^ !cmp;
  // Link clock stands still between frames
  initial begin
    pixel_input_clock = 1'b0;
    #7.3;
    forever begin
      #62.5;
      if (frame || pixel_input_clock) begin
        pixel_input_clock = ~pixel_input_clock;
      end
    end
  end
  // Word moves half a period away from the sampling edge
  always @(negedge pixel_input_clock) word <= next_word;
endmodule

// >>> tb/tb_top.sv
// Testbench: enable, pin direction, routing and capture over AXI4-Lite.
// Assumes the partner model and the bound checker compile beside it.
`timescale 1ns/100ps
module tb_top
  import fcp_pkg::*;
;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, vid_pixclk;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic external_sync_select, compat_external_sync_select;
  logic external_pixel_select, compat_external_pixel_select;
  logic external_pixclk_select, compat_external_pixclk_select;
  logic hsync_i, hsync_o, hsync_oe, vsync_i, vsync_o, vsync_oe, tgl;
  logic blank_n_i, blank_n_o, blank_n_oe, compat_blank_n_i, blank_lvl;
  logic compat_blank_n_o, compat_blank_n_oe, pixel_clock_pin_i, cmp;
  logic pixel_clock_pin_o, pixel_clock_pin_oe, feature_port_enable_n;
  logic pixel_input_clock, video_off, dac_ext_clk_sel, dac_pixel_valid;
  logic [PIX_W-1:0] pixel_bus_i, pixel_bus_o, pixel_bus_oe, vid_pixel;
  logic [PIX_W-1:0] compat_pixel_bus_o, compat_pixel_bus_oe, dac_pixel;
  logic [PIX_W-1:0] next_word, word;
  logic frame;
  fcp_video_t vid_in, ext_video;
  fcp_sel_t sel;
  int seed = 20550;
  int fail_count = 0;
  int compares = 0;
  int k, md, n;
  // Released sync and pixel clock lines wander; blank holds blank_lvl, pixel bus holds word, inverted while sel.pix is set
  assign hsync_i = hsync_oe ? hsync_o : tgl;
  assign vsync_i = vsync_oe ? vsync_o : !tgl;
  assign blank_n_i = blank_n_oe ? blank_n_o : blank_lvl;
  assign compat_blank_n_i = compat_blank_n_oe ? compat_blank_n_o : blank_lvl;
  assign pixel_bus_i = (pixel_bus_oe & pixel_bus_o) |
    (~pixel_bus_oe & (sel.pix ? ~word : word));
  assign pixel_clock_pin_i = pixel_clock_pin_oe ? pixel_clock_pin_o : tgl;
  fcp_port_ctrl dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .external_sync_select, .compat_external_sync_select,
    .external_pixel_select, .compat_external_pixel_select,
    .external_pixclk_select, .compat_external_pixclk_select, .hsync_i,
    .hsync_o, .hsync_oe, .vsync_i, .vsync_o, .vsync_oe, .blank_n_i,
    .blank_n_o, .blank_n_oe, .compat_blank_n_i, .compat_blank_n_o,
    .compat_blank_n_oe, .pixel_bus_i, .pixel_bus_o, .pixel_bus_oe,
    .compat_pixel_bus_o, .compat_pixel_bus_oe, .pixel_clock_pin_i,
    .pixel_clock_pin_o, .pixel_clock_pin_oe, .feature_port_enable_n,
    .pixel_input_clock, .vid_in, .vid_pixel, .vid_pixclk, .video_off,
    .ext_video, .dac_ext_clk_sel, .dac_pixel, .dac_pixel_valid);
  fcp_ext_dev ext (.sel, .cmp, .frame, .next_word, .external_sync_select,
    .compat_external_sync_select, .external_pixel_select,
    .compat_external_pixel_select, .external_pixclk_select,
    .compat_external_pixclk_select, .pixel_input_clock, .word);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    tgl = 1'b0;
    forever #9.7 tgl = ~tgl;
  end
  always @(posedge aclk) begin
    vid_in <= 3'($random(seed));
    vid_pixel <= 16'($random(seed));
    vid_pixclk <= ~vid_pixclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
    input string m);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s saw %h want %h", $time, m, seen, exp);
    end
  endtask
  // One transfer; a read leaves its word in d, both leave the code in r
  task automatic ax(input logic wr, input logic [4:0] a,
    input logic [31:0] v);
    int i;
    i = 0;
    @(posedge aclk);
    s_axi_awaddr <= {27'h0, a};
    s_axi_araddr <= {27'h0, a};
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    while (i < 200 && !(wr ? s_axi_bvalid : s_axi_rvalid)) begin
      @(posedge aclk);
      i++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    r = wr ? s_axi_bresp : s_axi_rresp;
    d = s_axi_rdata;
    {s_axi_bready, s_axi_rready} <= 2'b00;
  endtask
  // Let old handovers drain, then count fresh capture strobes
  task automatic grab(output int got);
    got = 0;
    repeat (300) @(posedge aclk);
    for (int i = 0; i < 200; i++) begin
      @(posedge aclk);
      #1;
      got += int'(dac_pixel_valid === 1'b1);
    end
  endtask
  function automatic logic [5:0] exp_dir(fcp_sel_t s, int m, logic bl);
    return {s.sync, s.sync & (m < 2), s.sync & (m == 2), s.pixclk,
      !s.pixclk, !s.sync & !bl};
  endfunction
  function automatic logic [15:0] exp_pix(fcp_sel_t s, int m);
    return m == 0 ? {16{s.pix}} : m == 1 ? {8'h00, {8{s.pix}}} : 16'h0000;
  endfunction
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, cmp} = 5'h00;
    {s_axi_arvalid, s_axi_rready, vid_pixclk, frame, sel} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, next_word} = '0;
    {ce, blank_lvl, s_axi_wstrb, vid_in, vid_pixel} = {6'h3F, 19'h0};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk({pixel_bus_oe, feature_port_enable_n}, 32'h1, "idle");
    for (k = 0; k < 3; k++) begin
      ax(1'b0, 5'(k * 4), 32'h0);
      chk(d, 32'h0, "reg reset");
    end
    ax(1'b0, 5'h14, 32'h0);
    chk(r, RESP_DECERR, "unmapped");
    $display("test reset done");
    for (k = 0; k < 5; k++) begin
      ax(1'b1, OFS_CTRL, k < 4 ? 32'h7 : 32'h6);
      ax(1'b1, OFS_PINFN, 32'(k % 4));
      repeat (2) @(posedge aclk);
      #1;
      chk(feature_port_enable_n, k != 0, "enable pin");
    end
    $display("test enable done");
    for (md = 0; md < 3; md++) begin
      ax(1'b1, OFS_CTRL, md == 0 ? 32'h7 : md == 1 ? 32'h3 : 32'h5);
      for (k = 0; k < 12; k++) begin
        @(posedge aclk);
        sel <= 3'(k < 8 ? k : $random(seed));
        cmp <= md == 2;
        blank_lvl <= 1'($random(seed));
        repeat (8) @(posedge aclk);
        #1;
        d = 32'({hsync_oe, blank_n_oe, compat_blank_n_oe,
          pixel_clock_pin_oe, dac_ext_clk_sel, video_off});
        chk(d, exp_dir(sel, md, blank_lvl), "dir");
        chk(pixel_bus_oe, exp_pix(sel, md), "pix");
        chk(compat_pixel_bus_oe, {16{sel.pix & (md == 2)}}, "cpix");
      end
    end
    $display("test direction done");
    ax(1'b1, OFS_CTRL, 32'h0);
    sel <= 3'h0;
    cmp <= 1'b0;
    blank_lvl <= 1'b0;
    repeat (8) @(posedge aclk);
    #1;
    d = 32'({pixel_bus_oe, hsync_oe, blank_n_oe, pixel_clock_pin_oe,
      dac_ext_clk_sel, video_off, feature_port_enable_n});
    chk(d, 32'h1, "disabled");
    // Link reset needs link clock edges, so run it through a second reset
    frame <= 1'b1;
    aresetn <= 1'b0;
    repeat (100) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    ax(1'b1, OFS_CTRL, 32'h7);
    ax(1'b1, OFS_PIXCFG, 32'h2);
    for (k = 0; k < 4; k++) begin
      next_word <= k == 0 ? 16'hFFFF : 16'($random(seed));
      grab(n);
      chk(dac_pixel, next_word, "capture");
      ax(1'b0, OFS_PIXDATA, 32'h0);
      chk(d, {16'h0, next_word}, "pixdata");
    end
    ax(1'b1, OFS_PIXCFG, 32'h0);
    grab(n);
    chk(n, 32'h0, "clock select off");
    ax(1'b1, OFS_CTRL, 32'h3);
    ax(1'b1, OFS_PIXCFG, 32'h2);
    grab(n);
    chk(n, 32'h0, "narrow mode");
    frame <= 1'b0;
    $display("test capture done");
    complete_run();
  end
endmodule
